// ---- hw/cps_ctrl.sv ----
// module: system clock prescaler and sleep clock gating
module cps_ctrl (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic div_eight_fuse_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic halt_in,
  input wire cps_pkg::cps_wake_t wake_in,
  input wire logic irq_enabled_in,
  input wire logic conv_enabled_in,
  input wire logic async_in_use_in,
  input wire logic [15:0] startup_cycles_in,
  output logic sys_clk_en_out,
  output cps_pkg::cps_gates_t gates_out,
  output logic core_stall_out,
  output logic conv_start_out,
  output logic sleeping_out
);
  import cps_pkg::*;

  cps_regs_t r;
  cps_regs_t next_r;
  logic wr_div;
  logic wake_hit;
  logic [3:0] eff_sel;
  logic [7:0] div_limit;

  assign wr_div = wr_in && addr_in == CPS_ADDR_DIVIDE;

  // reserved codes clamp to divide by 256
  always_comb begin
    eff_sel = (r.divide_select > CPS_SEL_MAX) ? CPS_SEL_MAX : r.divide_select;
  end

  always_comb begin
    case (r.sleep_mode_select)
      CPS_MODE_IDLE: wake_hit = |wake_in;
      CPS_MODE_QUIET: wake_hit = wake_in.ext_level_pin | wake_in.serial_start | wake_in.lcd
        | wake_in.async_timer | wake_in.self_program | wake_in.conv_done;
      CPS_MODE_PSAVE: wake_hit = wake_in.ext_level_pin | wake_in.serial_start | wake_in.lcd
        | wake_in.async_timer;
      default: wake_hit = wake_in.ext_level_pin | wake_in.serial_start;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.conv_start = 1'b0;
    next_r.rdata = 8'h00;
    // fuse value caught once after reset release
    if (!r.fuse_taken) begin
      next_r.fuse_taken = 1'b1;
      next_r.divide_select = div_eight_fuse_in ? CPS_SEL_FUSE : CPS_SEL_RESET;
      next_r.active_sel = next_r.divide_select;
    end
    if (r.divide_change_enable) begin
      if (r.ce_count == CPS_CE_CYCLES - 3'h1) begin
        next_r.divide_change_enable = 1'b0;
      end
      next_r.ce_count = r.ce_count + 3'h1;
    end
    if (wr_div) begin
      if (wdata_in == (8'h01 << CPS_CE_BIT)) begin
        // set only from clear; rewrite keeps window
        if (!r.divide_change_enable) begin
          next_r.divide_change_enable = 1'b1;
          next_r.ce_count = 3'h0;
        end
      end else if (r.divide_change_enable && !wdata_in[CPS_CE_BIT]) begin
        // any code accepted; select write clears
        next_r.divide_select = wdata_in[CPS_SEL_LSB +: CPS_SEL_W];
        next_r.divide_change_enable = 1'b0;
      end
    end
    if (wr_in && addr_in == CPS_ADDR_SLEEP) begin
      next_r.sleep_enable_bit = wdata_in[CPS_SE_BIT];
      next_r.sleep_mode_select = wdata_in[CPS_MODE_LSB +: 3];
    end
    // divider; new ratio only at a period boundary
    div_limit = 8'((16'h0001 << eff_sel) - 16'h0001);
    if (r.div_count >= 8'((16'h0001 << r.active_sel) - 16'h0001)) begin
      next_r.div_count = 8'h00;
      next_r.sys_clk_en = 1'b1;
      next_r.active_sel = eff_sel;
    end else begin
      next_r.div_count = r.div_count + 8'h01;
      next_r.sys_clk_en = 1'b0;
    end
    if (div_limit == 8'h00 && r.active_sel == 4'h0) begin
      next_r.sys_clk_en = 1'b1;
    end
    case (r.state)
      CPS_RUN: begin
        // halt sleeps only with enable set
        if (halt_in && r.sleep_enable_bit) begin
          next_r.state = CPS_SLEEP;
          next_r.conv_start = conv_enabled_in &&
            (r.sleep_mode_select == CPS_MODE_IDLE || r.sleep_mode_select == CPS_MODE_QUIET);
        end
      end
      CPS_SLEEP: begin
        if (wake_hit && irq_enabled_in) begin
          next_r.state = CPS_STARTUP;
          next_r.wait_count = startup_cycles_in;
        end
      end
      CPS_STARTUP: begin
        if (r.wait_count <= 16'h0001) begin
          next_r.state = CPS_STALL;
          next_r.wait_count = 16'(CPS_WAKE_STALL);
        end else begin
          next_r.wait_count = r.wait_count - 16'h0001;
        end
      end
      CPS_STALL: begin
        if (r.wait_count <= 16'h0001) begin
          next_r.state = CPS_RUN;
        end else begin
          next_r.wait_count = r.wait_count - 16'h0001;
        end
      end
      default: next_r.state = CPS_RUN;
    endcase
    if (rd_in) begin
      case (addr_in)
        CPS_ADDR_DIVIDE: next_r.rdata = {r.divide_change_enable, 3'h0, r.divide_select};
        CPS_ADDR_SLEEP: next_r.rdata = {4'h0, r.sleep_mode_select, r.sleep_enable_bit};
        CPS_ADDR_STATUS: next_r.rdata = {6'h00, r.state};
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  // reset wakes from any state to run; no storage touched here
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '{divide_select: CPS_SEL_RESET, active_sel: CPS_SEL_RESET,
             sleep_mode_select: CPS_MODE_IDLE, state: CPS_RUN,
             wait_count: CPS_STARTUP_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    gates_out = '1;
    if (r.state != CPS_RUN) begin
      gates_out.core = 1'b0;
      gates_out.flash = 1'b0;
      if (r.state == CPS_SLEEP) begin
        case (r.sleep_mode_select)
          CPS_MODE_IDLE: gates_out.timer_osc = async_in_use_in;
          CPS_MODE_QUIET: begin
            gates_out.io = 1'b0;
            gates_out.timer_osc = async_in_use_in;
          end
          CPS_MODE_PSAVE: begin
            gates_out.io = 1'b0;
            gates_out.conv = 1'b0;
            gates_out.main_osc = 1'b0;
          end
          CPS_MODE_STBY: begin
            gates_out.io = 1'b0;
            gates_out.conv = 1'b0;
            gates_out.async_clk = 1'b0;
            gates_out.timer_osc = 1'b0;
          end
          default: gates_out = '0;
        endcase
      end
    end
  end

  assign sys_clk_en_out = r.sys_clk_en;
  assign rdata_out = r.rdata;
  assign conv_start_out = r.conv_start;
  assign core_stall_out = r.state != CPS_RUN;
  assign sleeping_out = r.state == CPS_SLEEP;
endmodule

// ---- hw/cps_pkg.sv ----
// package: constants and carriers for the clock prescale and sleep controller
// Summary of operation
// - change enable set only with other bits zero
// - change enable clears after four cycles or select write
// - re-setting during window neither restarts nor clears
// - select field bits 3:0 divides system clock
// - codes 0-8 divide by 1..256; rest reserved
// - reset select 0000, or 0011 with fuse
// - any later select value accepted
// - sleep needs enable bit plus halt instruction
// - wake stalls core four cycles past start-up
// - register file and memory kept across sleep
// - reset during sleep restarts at reset vector
// - idle gates only core and flash clocks, plus timer oscillator when async clocking unused
// - idle wakes on any enabled interrupt
// - idle entry starts enabled converter conversion
// - per-mode clock and oscillator enables
// - wake sources differ per sleep mode
// - timer oscillator in idle/quiet only if async clocking used; always on in power-save
// - codes 001,010,011,110 select other modes
// - divider change glitch free, no short period
package cps_pkg;
  localparam logic [1:0] CPS_ADDR_DIVIDE = 2'h0;
  localparam logic [1:0] CPS_ADDR_SLEEP = 2'h1;
  localparam logic [1:0] CPS_ADDR_STATUS = 2'h2;
  localparam int CPS_CE_BIT = 7;
  localparam int CPS_SEL_LSB = 0;
  localparam int CPS_SEL_W = 4;
  localparam int CPS_SE_BIT = 0;
  localparam int CPS_MODE_LSB = 1;
  localparam logic [3:0] CPS_SEL_RESET = 4'h0;
  localparam logic [3:0] CPS_SEL_FUSE = 4'h3;
  localparam logic [3:0] CPS_SEL_MAX = 4'h8;
  localparam logic [2:0] CPS_CE_CYCLES = 3'h4;
  localparam logic [2:0] CPS_WAKE_STALL = 3'h4;
  localparam logic [2:0] CPS_MODE_IDLE = 3'h0;
  localparam logic [2:0] CPS_MODE_QUIET = 3'h1;
  localparam logic [2:0] CPS_MODE_PDOWN = 3'h2;
  localparam logic [2:0] CPS_MODE_PSAVE = 3'h3;
  localparam logic [2:0] CPS_MODE_STBY = 3'h6;
  localparam logic [15:0] CPS_STARTUP_RESET = 16'h0006;

  typedef enum logic [1:0] {CPS_RUN, CPS_SLEEP, CPS_STARTUP, CPS_STALL} cps_state_t;

  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic conv;
    logic async_clk;
    logic main_osc;
    logic timer_osc;
  } cps_gates_t;

  // wake request lines from the peripherals
  typedef struct packed {
    logic ext_level_pin;
    logic serial_start;
    logic lcd;
    logic async_timer;
    logic self_program;
    logic conv_done;
    logic other_io;
  } cps_wake_t;

  typedef struct packed {
    logic [3:0] divide_select;
    logic divide_change_enable;
    logic [2:0] ce_count;
    logic [7:0] div_count;
    logic [3:0] active_sel;
    logic sys_clk_en;
    logic sleep_enable_bit;
    logic [2:0] sleep_mode_select;
    cps_state_t state;
    logic [15:0] wait_count;
    logic [7:0] rdata;
    logic fuse_taken;
    logic conv_start;
  } cps_regs_t;
endpackage

// ---- test/cps_ctrl_monitor.sv ----
// checker: port-level properties of the prescaler and sleep controller
module cps_monitor
  import cps_pkg::*;
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic halt_in,
  input wire logic conv_enabled_in,
  input wire cps_pkg::cps_gates_t gates_out,
  input wire logic core_stall_out,
  input wire logic conv_start_out,
  input wire logic sleeping_out
);
  // shadow of the sleep control register, seen from the bus
  logic se_q;
  logic [2:0] mode_q;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      se_q <= 1'b0;
      mode_q <= 3'h0;
    end else if (wr_in && addr_in == CPS_ADDR_SLEEP) begin
      se_q <= wdata_in[CPS_SE_BIT];
      mode_q <= wdata_in[3:1];
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  property p_enter; halt_in && se_q && !core_stall_out |=> sleeping_out && core_stall_out; endproperty
  a_enter: assert property (p_enter) else $error("sleep not entered");
  property p_nose; halt_in && !se_q && !core_stall_out |=> !core_stall_out; endproperty
  a_nose: assert property (p_nose) else $error("halt without enable stalled");
  property p_run; !core_stall_out |-> gates_out.core && gates_out.flash; endproperty
  a_run: assert property (p_run) else $error("core clock off while running");
  property p_gate; sleeping_out |-> !gates_out.core && !gates_out.flash; endproperty
  a_gate: assert property (p_gate) else $error("core clock on in sleep");
  property p_idle; sleeping_out && mode_q == CPS_MODE_IDLE |-> gates_out[4:2] == 3'h7; endproperty
  a_idle: assert property (p_idle) else $error("idle clocks wrong");
  property p_stby; sleeping_out && mode_q == CPS_MODE_STBY |-> gates_out == 7'h02; endproperty
  a_stby: assert property (p_stby) else $error("standby clocks wrong");
  property p_conv;
    $rose(sleeping_out) && conv_enabled_in && mode_q == CPS_MODE_IDLE |-> ##[0:1] conv_start_out;
  endproperty
  a_conv: assert property (p_conv) else $error("no conversion on idle entry");
  property p_wake; $fell(sleeping_out) |-> core_stall_out [*5]; endproperty
  a_wake: assert property (p_wake) else $error("wake stall too short");
  c_pdown: cover property (sleeping_out && mode_q == CPS_MODE_PDOWN);
  c_wake: cover property ($fell(sleeping_out));
  c_conv: cover property (conv_start_out);
endmodule
bind cps_ctrl cps_monitor u_mon (.clock_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .halt_in,
  .conv_enabled_in, .gates_out, .core_stall_out, .conv_start_out, .sleeping_out);

// ---- test/cps_ctrl_tb_top.sv ----
// testbench: directed scenarios for the prescaler and sleep controller
module cps_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cps_pkg::*;
  logic clock_in = 1'b0, resetn_in = 1'b0, div_eight_fuse_in = 1'b0;
  logic wr_in = 1'b0, rd_in = 1'b0, halt_in = 1'b0;
  logic irq_enabled_in = 1'b1, conv_enabled_in = 1'b1, async_in_use_in = 1'b1;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00;
  logic [15:0] startup_cycles_in = 16'h0003;
  cps_wake_t wake_in = '0;
  logic [7:0] rdata_out;
  logic sys_clk_en_out, core_stall_out, conv_start_out, sleeping_out;
  cps_gates_t gates_out;
  int miscompares = 0, compares = 0, cyc = 0, convs = 0, p = 8;
  always #4 clock_in = ~clock_in;
  cps_ctrl u_dut (.clock_in, .resetn_in, .div_eight_fuse_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .halt_in, .wake_in, .irq_enabled_in, .conv_enabled_in,
    .async_in_use_in, .startup_cycles_in, .sys_clk_en_out, .gates_out, .core_stall_out,
    .conv_start_out, .sleeping_out);
  task end_sim;
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // pulse counted mid-cycle, away from the edge that launches it
  always @(negedge clock_in) begin
    if (conv_start_out) convs++;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      end_sim;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task acc(input logic w, r, h, input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_in <= w;
    rd_in <= r;
    halt_in <= h;
    addr_in <= a;
    wdata_in <= d;
  endtask
  task nop(input int n);
    repeat (n) acc(0, 0, 0, 2'h0, 8'h00);
  endtask
  task wd(input logic [7:0] d);
    acc(1, 0, 0, CPS_ADDR_DIVIDE, d);
  endtask
  task rdc(input logic [1:0] a, input logic [7:0] e);
    acc(0, 1, 0, a, 8'h00);
    nop(1);
    #1 chk(rdata_out, e);
  endtask
  task rst(input logic f);
    @(posedge clock_in);
    resetn_in <= 1'b0;
    div_eight_fuse_in <= f;
    repeat (5) @(posedge clock_in);
    resetn_in <= 1'b1;
  endtask
  task gap(output int n);
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (!sys_clk_en_out && n < 600);
  endtask
  task t_guard;
    wd(8'h81);
    wd(8'h05);
    rdc(CPS_ADDR_DIVIDE, 8'h03);
    wd(8'h80);
    nop(4);
    wd(8'h05);
    rdc(CPS_ADDR_DIVIDE, 8'h03);
    wd(8'h80);
    nop(1);
    wd(8'h80);
    nop(2);
    wd(8'h05);
    rdc(CPS_ADDR_DIVIDE, 8'h03);
    wd(8'h80);
    wd(8'h80);
    wd(8'h01);
    wd(8'h02);
    rdc(CPS_ADDR_DIVIDE, 8'h01);
    rdc(2'h3, 8'h00);
  endtask
  task t_div(input logic [3:0] s);
    int g1, g2, g3, e;
    e = (s > CPS_SEL_MAX) ? 256 : (1 << s);
    wd(8'h80);
    wd({4'h0, s});
    rdc(CPS_ADDR_DIVIDE, {4'h0, s});
    gap(g1);
    gap(g2);
    gap(g3);
    chk(g2 >= ((e < p) ? e : p), 1);
    chk(g3, e);
    p = e;
  endtask
  task t_nose;
    acc(1, 0, 0, CPS_ADDR_SLEEP, 8'h00);
    acc(0, 0, 1, 2'h0, 8'h00);
    nop(2);
    #1 chk(core_stall_out, 0);
  endtask
  task t_slp(input logic [2:0] m, input logic [6:0] g, input int cv);
    int n, c0;
    n = 0;
    c0 = convs;
    acc(1, 0, 0, CPS_ADDR_SLEEP, {4'h0, m, 1'b1});
    acc(0, 0, 1, 2'h0, 8'h00);
    nop(3);
    #1 chk(sleeping_out, 1);
    chk(gates_out, g);
    chk(convs - c0, cv);
    // a source outside every mode but idle must not wake
    @(posedge clock_in) wake_in <= 7'h01;
    repeat (10) begin
      @(negedge clock_in);
      n += (!sleeping_out && core_stall_out);
    end
    chk(sleeping_out, m != CPS_MODE_IDLE);
    @(posedge clock_in) wake_in <= 7'h40;
    repeat (50) begin
      @(negedge clock_in);
      n += (!sleeping_out && core_stall_out);
    end
    chk(n, startup_cycles_in + 4);
    chk(core_stall_out, 0);
    @(posedge clock_in) wake_in <= '0;
  endtask
  task t_rst;
    acc(1, 0, 0, CPS_ADDR_SLEEP, {4'h0, CPS_MODE_PDOWN, 1'b1});
    acc(0, 0, 1, 2'h0, 8'h00);
    nop(2);
    rst(1'b0);
    #1 chk(sleeping_out, 0);
    rdc(CPS_ADDR_DIVIDE, 8'h00);
  endtask
  initial begin
    rst(1'b1);
    rdc(CPS_ADDR_DIVIDE, 8'h03);
    t_guard;
    p = 2;
    // no wake or interrupt driven during divide sequences
    for (int s = 0; s < 10; s++) t_div(4'(s));
    t_nose;
    // comparator left out; idle wakes on other io
    t_slp(CPS_MODE_IDLE, 7'h1F, 1);
    t_slp(CPS_MODE_QUIET, 7'h0F, 1);
    t_slp(CPS_MODE_PDOWN, 7'h00, 0);
    t_slp(CPS_MODE_PSAVE, 7'h05, 0);
    // bench stands in for a crystal clocked part
    t_slp(CPS_MODE_STBY, 7'h02, 0);
    t_rst;
    end_sim;
  end
endmodule
